// ===== common/move_exec_cfg.svh
// How it works
// - file-to-file move carries full 12-bit source and destination addresses.
// - file-to-file move takes two words, two cycles, three if second word late.
// - working register may be source or destination of file-to-file move.
// - bank select load keeps literal low nibble, upper nibble forced zero.
// - opcode 0000 1110 loads literal into working register, no flags change.
// - access bit one uses bank select, zero uses shared access bank.
// - extended set, access bit zero, address up to 95 is indexed offset.
`ifndef MOVE_EXEC_CFG_SVH
`define MOVE_EXEC_CFG_SVH

// opcode fields
`define OPC_LIT_WORK 8'h0e
`define OPC_LIT_BANK 8'h01
`define OPC_WORK_FILE 7'h37
`define OPC_FILE_FIRST 4'hc
`define OPC_FILE_SECOND 4'hf

// data space layout
`define WORK_REG_ADDR 12'hfe8
`define ACCESS_SPLIT 8'h60
`define INDEX_LIMIT 8'h5f
`define ACCESS_HIGH_BANK 4'hf

// reset values
`define WORK_RESET 8'h00
`define BANK_RESET 8'h00

`endif

// ===== common/move_exec_pkg.sv
package move_exec_pkg;

	// four clocks of one instruction cycle
	typedef enum logic [1:0] {
		PH_DECODE,
		PH_READ,
		PH_PROCESS,
		PH_WRITE
	} phase_t;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_LIT_BANK,
		OP_LIT_WORK,
		OP_WORK_FILE,
		OP_FILE_FIRST,
		OP_FILE_SECOND
	} op_t;

endpackage : move_exec_pkg

// ===== logic/data_move_instruction_exec.sv
`timescale 1ns/10ps
`include "move_exec_cfg.svh"

module data_move_instruction_exec (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_instr_valid,
	input wire logic [15:0] i_instr,
	output logic o_instr_ready,
	input wire logic i_ext_set_en,
	input wire logic [11:0] i_index_base,
	output logic [11:0] o_mem_addr,
	output logic o_mem_rd,
	input wire logic [7:0] i_mem_rdata,
	output logic o_mem_wr,
	output logic [7:0] o_mem_wdata,
	output logic [7:0] o_work_reg,
	output logic [7:0] o_bank_select,
	output move_exec_pkg::phase_t o_phase
);
	import move_exec_pkg::*;

	phase_t phase;
	op_t op;
	logic [11:0] f_addr;
	logic [7:0] lit;
	logic [7:0] move_data;
	logic [7:0] work;
	logic [7:0] bank_select_register;
	logic second_pending;
	logic take;
	logic take_first;
	logic dest_is_work;

	// first-word decode, shared by the decoder and the checks
	function automatic op_t decode_op(input logic [15:0] w);
		if (w[15:8] == `OPC_LIT_WORK)
			return OP_LIT_WORK;
		else if (w[15:8] == `OPC_LIT_BANK)
			return OP_LIT_BANK;
		else if (w[15:9] == `OPC_WORK_FILE)
			return OP_WORK_FILE;
		else if (w[15:12] == `OPC_FILE_FIRST)
			return OP_FILE_FIRST;
		else
			return OP_NONE;
	endfunction : decode_op

	// byte address of an 8-bit file operand
	function automatic logic [11:0] file_addr(input logic acc, input logic [7:0] f,
		input logic [7:0] bsel, input logic ext, input logic [11:0] base);
		if (acc)
			return {bsel[3:0], f};
		else if (ext && f <= `INDEX_LIMIT)
			return 12'(base + {4'h0, f});
		else if (f < `ACCESS_SPLIT)
			return {4'h0, f};
		else
			return {`ACCESS_HIGH_BANK, f};
	endfunction : file_addr

	// fetch is offered only in the decode phase
	assign o_instr_ready = (phase == PH_DECODE);
	assign take = o_instr_ready && i_instr_valid;
	assign take_first = take && !second_pending;
	// the working register lives in the data space, so moves to it stay internal
	assign dest_is_work = (f_addr == `WORK_REG_ADDR);

	// phase sequencer; an idle decode still spends a full cycle as a nop
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			phase <= PH_DECODE;
		else
		begin
			case (phase)
				PH_DECODE: phase <= PH_READ;
				PH_READ: phase <= PH_PROCESS;
				PH_PROCESS: phase <= PH_WRITE;
				PH_WRITE: phase <= PH_DECODE;
				default: phase <= PH_DECODE;
			endcase
		end
	end

	// decode; a late second word costs whole nop cycles, the third cycle case
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			op <= OP_NONE;
			f_addr <= 12'h000;
			lit <= 8'h00;
			second_pending <= 1'b0;
		end
		else if (phase == PH_DECODE)
		begin
			if (!i_instr_valid)
				op <= OP_NONE;
			else if (second_pending)
			begin
				op <= OP_FILE_SECOND;
				f_addr <= i_instr[11:0];
				second_pending <= 1'b0;
			end
			else
			begin
				op <= decode_op(i_instr);
				lit <= i_instr[7:0];
				if (decode_op(i_instr) == OP_FILE_FIRST)
				begin
					f_addr <= i_instr[11:0];
					second_pending <= 1'b1;
				end
				else
					f_addr <= file_addr(i_instr[8], i_instr[7:0], bank_select_register,
						i_ext_set_en, i_index_base);
			end
		end
	end

	// operand read strobe in the read phase; source W needs no bus read
	assign o_mem_rd = (phase == PH_READ) && (op == OP_FILE_FIRST) && !dest_is_work;
	assign o_mem_addr = f_addr;

	// process phase latches the byte being moved, unchanged
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			move_data <= 8'h00;
		else if (phase == PH_PROCESS)
		begin
			if (op == OP_FILE_FIRST)
				move_data <= dest_is_work ? work : i_mem_rdata;
			else if (op == OP_WORK_FILE)
				move_data <= work;
		end
	end

	// write phase to the data space
	assign o_mem_wr = (phase == PH_WRITE) && !dest_is_work &&
		(op == OP_WORK_FILE || op == OP_FILE_SECOND);
	assign o_mem_wdata = move_data;

	// working register; no status flags exist here since none are touched
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			work <= `WORK_RESET;
		else if (phase == PH_WRITE)
		begin
			if (op == OP_LIT_WORK)
				work <= lit;
			else if (dest_is_work && (op == OP_FILE_SECOND || op == OP_WORK_FILE))
				work <= move_data;
		end
	end

	// bank select; upper nibble can never be set
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			bank_select_register <= `BANK_RESET;
		else if (phase == PH_WRITE && op == OP_LIT_BANK)
			bank_select_register <= {4'h0, lit[3:0]};
	end

	assign o_work_reg = work;
	assign o_bank_select = bank_select_register;
	assign o_phase = phase;

	// checks
	sequence s_phases;
		phase == PH_READ ##1 phase == PH_PROCESS ##1 phase == PH_WRITE ##1 phase == PH_DECODE;
	endsequence

	property p_cycle_len;
		@(posedge i_clk) disable iff (i_sys_rst)
		phase == PH_DECODE |=> s_phases;
	endproperty
	a_cycle_len: assert property (p_cycle_len) else $error("phase order broken");

	property p_bank_hi;
		@(posedge i_clk) disable iff (i_sys_rst)
		o_bank_select[7:4] == 4'h0;
	endproperty
	a_bank_hi: assert property (p_bank_hi) else $error("bank upper nibble set");

	property p_bank_low;
		@(posedge i_clk) disable iff (i_sys_rst)
		take_first && decode_op(i_instr) == OP_LIT_BANK |->
			##4 o_bank_select == {4'h0, $past(i_instr[3:0], 4)};
	endproperty
	a_bank_low: assert property (p_bank_low) else $error("bank load wrong");

	property p_lit_work;
		@(posedge i_clk) disable iff (i_sys_rst)
		take_first && decode_op(i_instr) == OP_LIT_WORK |->
			##4 o_work_reg == $past(i_instr[7:0], 4);
	endproperty
	a_lit_work: assert property (p_lit_work) else $error("literal load wrong");

	property p_store_bank;
		@(posedge i_clk) disable iff (i_sys_rst)
		take_first && decode_op(i_instr) == OP_WORK_FILE && i_instr[8] |->
			##3 o_mem_addr == {o_bank_select[3:0], $past(i_instr[7:0], 3)};
	endproperty
	a_store_bank: assert property (p_store_bank) else $error("banked address wrong");

	property p_store_access;
		@(posedge i_clk) disable iff (i_sys_rst)
		take_first && decode_op(i_instr) == OP_WORK_FILE && !i_instr[8] &&
			!(i_ext_set_en && i_instr[7:0] <= `INDEX_LIMIT) |->
			##3 o_mem_addr[7:0] == $past(i_instr[7:0], 3) &&
			o_mem_addr[11:8] == (o_mem_addr[7:0] < `ACCESS_SPLIT ? 4'h0 : 4'hf);
	endproperty
	a_store_access: assert property (p_store_access) else $error("access address wrong");

	property p_indexed;
		@(posedge i_clk) disable iff (i_sys_rst)
		take_first && decode_op(i_instr) == OP_WORK_FILE && !i_instr[8] &&
			i_ext_set_en && i_instr[7:0] <= `INDEX_LIMIT |->
			##3 o_mem_addr == 12'($past(i_index_base, 3) + {4'h0, $past(i_instr[7:0], 3)});
	endproperty
	a_indexed: assert property (p_indexed) else $error("indexed address wrong");

	property p_ff_write;
		@(posedge i_clk) disable iff (i_sys_rst)
		take && second_pending && i_instr[11:0] != `WORK_REG_ADDR |->
			##3 o_mem_wr && o_mem_addr == $past(i_instr[11:0], 3);
	endproperty
	a_ff_write: assert property (p_ff_write) else $error("move destination wrong");

	property p_ff_no_early_write;
		@(posedge i_clk) disable iff (i_sys_rst)
		take_first && decode_op(i_instr) == OP_FILE_FIRST |-> ##1 (!o_mem_wr)[*6];
	endproperty
	a_ff_no_early_write: assert property (p_ff_no_early_write) else $error("early write");

endmodule : data_move_instruction_exec

// ===== tb/mem_model.sv
`timescale 1ns/10ps
module mem_model (
	input wire logic i_clk,
	input wire logic [11:0] i_addr,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [4096];
	// whole 12-bit space seeded from the address
	initial
	begin
		for (int i = 0; i < 4096; i++)
			mem[i] = 8'(i ^ (i >> 4));
		o_rdata = 8'h00;
	end
	// data good one clock after the strobe, scrambled otherwise so stale reads show
	always @(posedge i_clk)
	begin
		o_rdata <= i_rd ? mem[i_addr] : ~o_rdata;
		if (i_wr)
			mem[i_addr] <= i_wdata;
	end
endmodule : mem_model

// ===== tb/data_move_instruction_exec_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
$display("mismatch %s exp %h got %h", nm, e, g); end end
module data_move_instruction_exec_tb;
	import move_exec_pkg::*;
	logic i_clk = 1'b0, i_sys_rst = 1'b1, i_instr_valid = 1'b0, i_ext_set_en = 1'b0;
	logic [15:0] i_instr = 16'h0000;
	logic [11:0] i_index_base = 12'h000, o_mem_addr;
	logic o_instr_ready, o_mem_rd, o_mem_wr;
	logic [7:0] i_mem_rdata, o_mem_wdata, o_work_reg, o_bank_select;
	phase_t o_phase;
	int mismatches = 0, comparisons = 0, ew = 0, eb = 0, adr, k, a, f, s, d, x, b;
	int exp_mem [4096];
	data_move_instruction_exec i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_instr_valid(i_instr_valid), .i_instr(i_instr), .o_instr_ready(o_instr_ready),
		.i_ext_set_en(i_ext_set_en), .i_index_base(i_index_base), .o_mem_addr(o_mem_addr),
		.o_mem_rd(o_mem_rd), .i_mem_rdata(i_mem_rdata), .o_mem_wr(o_mem_wr),
		.o_mem_wdata(o_mem_wdata), .o_work_reg(o_work_reg), .o_bank_select(o_bank_select),
		.o_phase(o_phase));
	mem_model i_mem (.i_clk(i_clk), .i_addr(o_mem_addr), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
		.i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
	// 100 mhz clock
	initial
	begin
		forever #5 i_clk = ~i_clk;
	end
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop
	// offer one word in the decode slot that follows the next write phase
	task issue(input logic [15:0] w);
		int n;
		n = 0;
		@(negedge i_clk);
		while (o_phase !== PH_WRITE && n < 8)
		begin
			@(negedge i_clk);
			n++;
		end
		// a wait that ran out shows here as a wrong phase
		`CHK("phase", PH_WRITE, o_phase)
		@(posedge i_clk);
		i_instr_valid <= 1'b1;
		i_instr <= w;
		i_ext_set_en <= 1'(x);
		i_index_base <= 12'(b);
		@(negedge i_clk);
		`CHK("ready", 1'b1, o_instr_ready)
		@(posedge i_clk);
		i_instr_valid <= 1'b0;
	endtask : issue
	// wait for the cycle to finish, then compare state with the model
	task settle;
		int n;
		n = 0;
		@(negedge i_clk);
		while (o_phase !== PH_DECODE && n < 8)
		begin
			@(negedge i_clk);
			n++;
		end
		`CHK("phase", PH_DECODE, o_phase)
		`CHK("work", 8'(ew), o_work_reg)
		`CHK("bank", 8'(eb), o_bank_select)
		if (adr != 12'hfe8)
			`CHK("mem", 8'(exp_mem[adr]), i_mem.mem[adr])
	endtask : settle
	// watchdog, far beyond the few thousand cycles the run needs
	initial
	begin
		#500000;
		mismatches++;
		report_and_stop();
	end
	initial
	begin
		void'($urandom(32'hd7db5bed));
		for (int i = 0; i < 4096; i++)
			exp_mem[i] = (i ^ (i >> 4)) & 255;
		repeat (3) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		adr = 12'hfe8;
		x = 0;
		b = 0;
		for (int t = 0; t < 240; t++)
		begin
			k = $urandom_range(0, 3);
			f = $urandom_range(0, 255);
			x = $urandom_range(0, 1);
			b = $urandom_range(0, 4095);
			a = $urandom_range(0, 1);
			if (k == 0)
			begin
				issue(16'(16'h0e00 | f));
				ew = f;
			end
			else if (k == 1)
			begin
				issue(16'(16'h0100 | f));
				eb = f & 15;
			end
			else if (k == 2)
			begin
				// bank, indexed or access bank address
				adr = a ? (eb << 8) | f : (x && f <= 8'h5f) ? (b + f) & 12'hfff :
					(f < 8'h60) ? f : 12'hf00 | f;
				issue(16'(16'h6e00 | (a << 8) | f));
				if (adr != 12'hfe8)
					exp_mem[adr] = ew;
			end
			else
			begin
				s = a ? 12'hfe8 : $urandom_range(0, 4095);
				// keep clear of the counter and stack bytes at the top
				d = x ? 12'hfe8 : $urandom_range(0, 12'hf7f);
				issue(16'(16'hc000 | s));
				if (f[0])
					repeat (4) @(posedge i_clk);
				issue(16'(16'hf000 | d));
				adr = d;
				if (d == 12'hfe8)
					ew = (s == 12'hfe8) ? ew : exp_mem[s];
				else
					exp_mem[d] = (s == 12'hfe8) ? ew : exp_mem[s];
			end
			settle();
			// mid-run reset: registers clear, the data space keeps its bytes
			if (t == 120)
			begin
				@(posedge i_clk);
				i_sys_rst <= 1'b1;
				repeat (2) @(posedge i_clk);
				i_sys_rst <= 1'b0;
				ew = 0;
				eb = 0;
				@(negedge i_clk);
				`CHK("ready", 1'b1, o_instr_ready)
				`CHK("work", 8'(ew), o_work_reg)
				`CHK("bank", 8'(eb), o_bank_select)
			end
		end
		report_and_stop();
	end
endmodule : data_move_instruction_exec_tb
